/* File: core/ssr_map.svh */
// register selectors, bit positions, limits and reset values of the status registers
`ifndef SSR_MAP_SVH
`define SSR_MAP_SVH

// register selectors on the command port
`define SSR_SEL_OP_EVENT   4'h0
`define SSR_SEL_OP_COND    4'h1
`define SSR_SEL_OP_ENABLE  4'h2
`define SSR_SEL_DQ_EVENT   4'h3
`define SSR_SEL_DQ_COND    4'h4
`define SSR_SEL_DQ_ENABLE  4'h5
`define SSR_SEL_PH_EVENT   4'h6
`define SSR_SEL_PH_COND    4'h7
`define SSR_SEL_PH_ENABLE  4'h8
`define SSR_SEL_PH_RISE    4'h9
`define SSR_SEL_PH_FALL    4'ha
`define SSR_SEL_PHASE      4'hb

// operation bit positions
`define SSR_OP_CAL         0
`define SSR_OP_TRANSIENT   3
`define SSR_OP_MEASURE     4

// doubtful-status bit positions
`define SSR_DQ_VOLT        0
`define SSR_DQ_OVERCUR     1
`define SSR_DQ_OVERTEMP    3
`define SSR_DQ_INHIBIT     9
`define SSR_DQ_ILIMIT      12
`define SSR_DQ_USED        16'h120b

// status byte bit positions
`define SSR_SB_DQ          3
`define SSR_SB_OP          7

// write limits
`define SSR_OP_ENABLE_MAX  16'h7fd7
`define SSR_PH_ENABLE_MAX  16'h7fff
`define SSR_PHASE_LAST     2'h2

// reset values
`define SSR_OP_ENABLE_RST  16'h0000
`define SSR_DQ_ENABLE_RST  16'h0000
`define SSR_PH_ENABLE_RST  16'h0000
`define SSR_PH_RISE_RST    16'h120b
`define SSR_PH_FALL_RST    16'h0000
`define SSR_PHASE_RST      2'h0

`endif

/* File: core/ssr_pkg.sv */
// types shared by the status register bank
package ssr_pkg;

    typedef struct packed {
        logic measurement_done;
        logic transient_done;
        logic cal_done;
    } ssr_op_t;

    typedef struct packed {
        logic rms_current_limiting;
        logic remote_inhibit_active;
        logic over_temperature_trip;
        logic overcurrent_trip;
        logic voltage_fault_trip;
    } ssr_fault_t;

    typedef struct packed {
        logic        write;
        logic [3:0]  sel;
        logic [15:0] wdata;
    } ssr_cmd_t;

endpackage

/* File: core/ssr_status.sv */
// status summary register bank with per-phase doubtful-status groups
`timescale 1ns/1ps
`include "ssr_map.svh"

module ssr_status (
    // clock and reset
    input  wire logic                        clk_i,
    input  wire logic                        reset_n_i,
    // status sources, asynchronous
    input  ssr_pkg::ssr_op_t                 op_done_i,
    input  ssr_pkg::ssr_fault_t              fault_i,
    input  ssr_pkg::ssr_fault_t [2:0]        phase_fault_i,
    // remote command port
    input  wire logic                        cmd_valid_i,
    input  ssr_pkg::ssr_cmd_t                cmd_i,
    output logic                             rsp_valid_o,
    output logic [15:0]                      rsp_data_o,
    output logic                             rsp_error_o,
    // summaries
    output logic [7:0]                       status_byte_o,
    output logic [2:0]                       per_phase_summary_o
);

    function automatic logic [15:0] fault_word(input ssr_pkg::ssr_fault_t f);
        logic [15:0] w;
        w = 16'h0000;
        w[`SSR_DQ_VOLT]     = f.voltage_fault_trip;
        w[`SSR_DQ_OVERCUR]  = f.overcurrent_trip;
        w[`SSR_DQ_OVERTEMP] = f.over_temperature_trip;
        w[`SSR_DQ_INHIBIT]  = f.remote_inhibit_active;
        w[`SSR_DQ_ILIMIT]   = f.rms_current_limiting;
        return w;
    endfunction

    function automatic logic [15:0] op_word(input ssr_pkg::ssr_op_t o);
        logic [15:0] w;
        w = 16'h0000;
        w[`SSR_OP_CAL]   = o.cal_done;
        w[`SSR_OP_TRANSIENT] = o.transient_done;
        w[`SSR_OP_MEASURE]   = o.measurement_done;
        return w;
    endfunction

    function automatic logic [15:0] edges(input logic [15:0] now, input logic [15:0] prev,
                                          input logic [15:0] rise, input logic [15:0] fall);
        return (now & ~prev & rise) | (~now & prev & fall);
    endfunction

    // synchronisers; the first stage feeds only the second
    ssr_pkg::ssr_op_t           op_s1, op_s2, op_prev;
    ssr_pkg::ssr_fault_t        dq_s1, dq_s2, dq_prev;
    ssr_pkg::ssr_fault_t [2:0]  ph_s1, ph_s2, ph_prev;

    // register state
    logic [15:0]        op_event, dq_event, op_enable, dq_enable;
    logic [2:0][15:0]   ph_event, ph_enable, ph_rise, ph_fall;
    logic [1:0]         phase_sel;
    logic [15:0]        next_op_event, next_dq_event, next_op_enable, next_dq_enable;
    logic [2:0][15:0]   next_ph_event, next_ph_enable, next_ph_rise, next_ph_fall;
    logic [1:0]         next_phase_sel;
    logic               next_rsp_valid, next_rsp_error;
    logic [15:0]        next_rsp_data;
    logic [7:0]         next_status_byte;
    logic [2:0]         next_per_phase_summary;

    // decoded
    logic        rd, wr, op_clr, dq_clr;
    logic [15:0] op_cond, dq_cond, op_set, dq_set;
    logic [2:0]  ph_clr;

    always_comb
    begin
        rd      = cmd_valid_i & ~cmd_i.write;
        wr      = cmd_valid_i & cmd_i.write;
        op_cond = op_word(op_s2);
        dq_cond = fault_word(dq_s2);
        // main groups latch every rising condition
        op_set  = edges(op_cond, op_word(op_prev), 16'hffff, 16'h0000);
        dq_set  = edges(dq_cond, fault_word(dq_prev), 16'hffff, 16'h0000);
        op_clr  = rd & (cmd_i.sel == `SSR_SEL_OP_EVENT);
        dq_clr  = rd & (cmd_i.sel == `SSR_SEL_DQ_EVENT);
        ph_clr  = 3'h0;
        ph_clr[phase_sel] = rd & (cmd_i.sel == `SSR_SEL_PH_EVENT);

        next_op_enable = op_enable;
        next_dq_enable = dq_enable;
        next_ph_enable = ph_enable;
        next_ph_rise   = ph_rise;
        next_ph_fall   = ph_fall;
        next_phase_sel = phase_sel;
        next_rsp_valid = cmd_valid_i;
        next_rsp_data  = 16'h0000;
        next_rsp_error = 1'b0;

        // a set in the clearing cycle survives the clear
        next_op_event = (op_event & ~{16{op_clr}}) | op_set;
        next_dq_event = (dq_event & ~{16{dq_clr}}) | dq_set;
        for (int p = 0; p < 3; p++)
        begin
            next_ph_event[p] = (ph_event[p] & ~{16{ph_clr[p]}})
                             | edges(fault_word(ph_s2[p]), fault_word(ph_prev[p]),
                                     ph_rise[p], ph_fall[p]);
        end

        if (rd)
        begin
            case (cmd_i.sel)
                `SSR_SEL_OP_EVENT:  next_rsp_data = op_event;
                `SSR_SEL_OP_COND:   next_rsp_data = op_cond;
                `SSR_SEL_OP_ENABLE: next_rsp_data = op_enable;
                `SSR_SEL_DQ_EVENT:  next_rsp_data = dq_event;
                `SSR_SEL_DQ_COND:   next_rsp_data = dq_cond;
                `SSR_SEL_DQ_ENABLE: next_rsp_data = dq_enable;
                `SSR_SEL_PH_EVENT:  next_rsp_data = ph_event[phase_sel];
                `SSR_SEL_PH_COND:   next_rsp_data = fault_word(ph_s2[phase_sel]);
                `SSR_SEL_PH_ENABLE: next_rsp_data = ph_enable[phase_sel];
                `SSR_SEL_PH_RISE:   next_rsp_data = ph_rise[phase_sel];
                `SSR_SEL_PH_FALL:   next_rsp_data = ph_fall[phase_sel];
                `SSR_SEL_PHASE:     next_rsp_data = {14'h0000, phase_sel};
                default:            next_rsp_error = 1'b1;
            endcase
        end
        else if (wr)
        begin
            // out-of-range values are refused, the register keeps its value
            case (cmd_i.sel)
                `SSR_SEL_OP_ENABLE:
                begin
                    if (cmd_i.wdata > `SSR_OP_ENABLE_MAX)
                        next_rsp_error = 1'b1;
                    else
                        next_op_enable = cmd_i.wdata;
                end
                `SSR_SEL_DQ_ENABLE: next_dq_enable = cmd_i.wdata;
                `SSR_SEL_PH_ENABLE:
                begin
                    if (cmd_i.wdata > `SSR_PH_ENABLE_MAX)
                        next_rsp_error = 1'b1;
                    else
                        next_ph_enable[phase_sel] = cmd_i.wdata;
                end
                `SSR_SEL_PH_RISE:   next_ph_rise[phase_sel] = cmd_i.wdata & `SSR_DQ_USED;
                `SSR_SEL_PH_FALL:   next_ph_fall[phase_sel] = cmd_i.wdata & `SSR_DQ_USED;
                `SSR_SEL_PHASE:
                begin
                    if (cmd_i.wdata > {14'h0000, `SSR_PHASE_LAST})
                        next_rsp_error = 1'b1;
                    else
                        next_phase_sel = cmd_i.wdata[1:0];
                end
                // event and condition registers take no writes
                default:            next_rsp_error = 1'b1;
            endcase
        end

        // summaries follow the registers each cycle, one flop later
        next_status_byte = 8'h00;
        next_status_byte[`SSR_SB_OP] = |(op_event & op_enable);
        next_status_byte[`SSR_SB_DQ] = |(dq_event & dq_enable);
        for (int p = 0; p < 3; p++)
        begin
            next_per_phase_summary[p] = |(ph_event[p] & ph_enable[p]);
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i)
    begin
        if (!reset_n_i)
        begin
            op_s1               <= '0;
            op_s2               <= '0;
            op_prev             <= '0;
            dq_s1               <= '0;
            dq_s2               <= '0;
            dq_prev             <= '0;
            ph_s1               <= '0;
            ph_s2               <= '0;
            ph_prev             <= '0;
            op_event            <= 16'h0000;
            dq_event            <= 16'h0000;
            ph_event            <= '0;
            op_enable           <= `SSR_OP_ENABLE_RST;
            dq_enable           <= `SSR_DQ_ENABLE_RST;
            ph_enable           <= {3{`SSR_PH_ENABLE_RST}};
            ph_rise             <= {3{`SSR_PH_RISE_RST}};
            ph_fall             <= {3{`SSR_PH_FALL_RST}};
            phase_sel           <= `SSR_PHASE_RST;
            rsp_valid_o         <= 1'b0;
            rsp_data_o          <= 16'h0000;
            rsp_error_o         <= 1'b0;
            status_byte_o       <= 8'h00;
            per_phase_summary_o <= 3'h0;
        end
        else
        begin
            op_s1               <= op_done_i;
            op_s2               <= op_s1;
            op_prev             <= op_s2;
            dq_s1               <= fault_i;
            dq_s2               <= dq_s1;
            dq_prev             <= dq_s2;
            ph_s1               <= phase_fault_i;
            ph_s2               <= ph_s1;
            ph_prev             <= ph_s2;
            op_event            <= next_op_event;
            dq_event            <= next_dq_event;
            ph_event            <= next_ph_event;
            op_enable           <= next_op_enable;
            dq_enable           <= next_dq_enable;
            ph_enable           <= next_ph_enable;
            ph_rise             <= next_ph_rise;
            ph_fall             <= next_ph_fall;
            phase_sel           <= next_phase_sel;
            rsp_valid_o         <= next_rsp_valid;
            rsp_data_o          <= next_rsp_data;
            rsp_error_o         <= next_rsp_error;
            status_byte_o       <= next_status_byte;
            per_phase_summary_o <= next_per_phase_summary;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence dq_read_s;
        rd && cmd_i.sel == `SSR_SEL_DQ_EVENT;
    endsequence

    sequence op_read_s;
        rd && cmd_i.sel == `SSR_SEL_OP_EVENT;
    endsequence

    chk_run_summary: assert property (
        ##1 status_byte_o[`SSR_SB_OP] == $past(|(op_event & op_enable)))
        else $error("run summary bit wrong");
    chk_op_enable_limit: assert property (
        wr && cmd_i.sel == `SSR_SEL_OP_ENABLE && cmd_i.wdata > 16'h7fd7
        |=> rsp_error_o && op_enable == $past(op_enable))
        else $error("operation enable accepted out of range");
    chk_vf_weight: assert property (
        dq_s2.voltage_fault_trip && !dq_prev.voltage_fault_trip |=> dq_event[0])
        else $error("voltage fault not latched at weight 1");
    chk_ot_weight: assert property (
        dq_s2.over_temperature_trip && !dq_prev.over_temperature_trip |=> dq_event[3])
        else $error("over-temperature not latched at weight 8");
    chk_unused_bits: assert property (
        (dq_event & ~16'h120b) == 16'h0000)
        else $error("unused doubtful bit set");
    chk_dq_sticky: assert property (
        !dq_clr |=> (dq_event & $past(dq_event)) == $past(dq_event))
        else $error("doubtful event bit lost without clear");
    chk_dq_read_clear: assert property (
        dq_read_s ##0 (dq_set == 16'h0000) |=> rsp_valid_o
        && rsp_data_o == $past(dq_event) && dq_event == 16'h0000)
        else $error("doubtful event read did not return and clear");
    chk_dq_cond_live: assert property (
        rd && cmd_i.sel == `SSR_SEL_DQ_COND |=> rsp_data_o == $past(dq_cond))
        else $error("doubtful condition not live");
    chk_dq_summary: assert property (
        ##1 status_byte_o[`SSR_SB_DQ] == $past(|(dq_event & dq_enable)))
        else $error("status bit 3 wrong");
    chk_phase_enable: assert property (
        wr && cmd_i.sel == `SSR_SEL_PH_ENABLE && cmd_i.wdata <= 16'h7fff
        |=> ph_enable[$past(phase_sel)] == $past(cmd_i.wdata))
        else $error("phase enable not written to selected phase");
    chk_phase_filter: assert property (
        ph_clr == 3'h0 && $stable(ph_s2) |=> $stable(ph_event))
        else $error("phase event latched without transition");
    chk_op_read_clear: assert property (
        op_read_s ##0 (op_set == 16'h0000) |=> op_event == 16'h0000)
        else $error("operation event not cleared by read");
    chk_cf_weight: assert property (
        dq_s2.overcurrent_trip && !dq_prev.overcurrent_trip |=> dq_event[`SSR_DQ_OVERCUR])
        else $error("overcurrent not latched at weight 2");
    chk_ri_weight: assert property (
        dq_s2.remote_inhibit_active && !dq_prev.remote_inhibit_active
        |=> dq_event[`SSR_DQ_INHIBIT])
        else $error("remote inhibit not latched at weight 512");
    chk_cl_weight: assert property (
        dq_s2.rms_current_limiting && !dq_prev.rms_current_limiting
        |=> dq_event[`SSR_DQ_ILIMIT])
        else $error("current limiting not latched at weight 4096");
    chk_ph_enable_limit: assert property (
        wr && cmd_i.sel == `SSR_SEL_PH_ENABLE && cmd_i.wdata > `SSR_PH_ENABLE_MAX
        |=> rsp_error_o && ph_enable == $past(ph_enable))
        else $error("phase enable accepted out of range");
    chk_op_weights: assert property (
        op_s2.transient_done && !op_prev.transient_done |=> op_event[`SSR_OP_TRANSIENT])
        else $error("transient done not latched at weight 8");

endmodule

/* File: verif/ssr_status_test.sv */
// self-checking bench for the status summary register bank
`timescale 1ns/1ps

`define CHK(got, exp) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            num_errors++; \
            $display("unexpected at %0t: got %h expected %h", $time, got, exp); \
        end \
    end

module ssr_status_test;
    logic                      clk_i;
    logic                      reset_n_i;
    ssr_pkg::ssr_op_t          op_done_i;
    ssr_pkg::ssr_fault_t       fault_i;
    ssr_pkg::ssr_fault_t [2:0] phase_fault_i;
    logic                      cmd_valid_i;
    ssr_pkg::ssr_cmd_t         cmd_i;
    logic                      rsp_valid_o;
    logic [15:0]               rsp_data_o;
    logic                      rsp_error_o;
    logic [7:0]                status_byte_o;
    logic [2:0]                per_phase_summary_o;
    int                        num_errors = 0;
    int                        n_compared = 0;
    // model of the registers, reckoned as settled values
    int                        op_ev, dq_ev, op_en, dq_en, op_old, dq_old;
    int                        ph_ev [3];
    int                        ph_en [3];
    int                        rise [3];
    int                        fall [3];
    int                        ph_old [3];
    logic [15:0]               rd;
    logic [31:0]               v;
    int                        p;
    logic [3:0]                ro_sel [6] = '{4'h0, 4'h1, 4'h3, 4'h4, 4'h6, 4'h7};

    ssr_status DUT (
        .clk_i               (clk_i),
        .reset_n_i           (reset_n_i),
        .op_done_i           (op_done_i),
        .fault_i             (fault_i),
        .phase_fault_i       (phase_fault_i),
        .cmd_valid_i         (cmd_valid_i),
        .cmd_i               (cmd_i),
        .rsp_valid_o         (rsp_valid_o),
        .rsp_data_o          (rsp_data_o),
        .rsp_error_o         (rsp_error_o),
        .status_byte_o       (status_byte_o),
        .per_phase_summary_o (per_phase_summary_o)
    );

    always #2 clk_i = ~clk_i;

    function automatic int fmap(ssr_pkg::ssr_fault_t f);
        return {f.rms_current_limiting, 2'h0, f.remote_inhibit_active, 5'h00,
                f.over_temperature_trip, 1'b0, f.overcurrent_trip, f.voltage_fault_trip};
    endfunction

    function automatic int omap(ssr_pkg::ssr_op_t o);
        return {o.measurement_done, o.transient_done, 2'h0, o.cal_done};
    endfunction

    task automatic test_done();
        $display("compared %0d, errors %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // one command, answer looked at in its single cycle
    task automatic cmd(input logic w, input logic [3:0] s, input logic [15:0] d, input logic e);
        @(posedge clk_i);
        cmd_valid_i <= 1'b1;
        cmd_i <= '{write: w, sel: s, wdata: d};
        @(posedge clk_i);
        cmd_valid_i <= 1'b0;
        #1;
        `CHK(rsp_valid_o, 1'b1)
        `CHK(rsp_error_o, e)
        rd = rsp_data_o;
    endtask

    task automatic rdchk(input logic [3:0] s, input int exp);
        cmd(1'b0, s, 16'h0000, 1'b0);
        `CHK(rd, exp[15:0])
    endtask

    task automatic sums();
        logic [2:0] pp;
        logic [7:0] sb;
        repeat (2) @(posedge clk_i);
        #1;
        for (int i = 0; i < 3; i++)
            pp[i] = (ph_ev[i] & ph_en[i]) != 0;
        sb = 8'h00;
        sb[7] = (op_ev & op_en) != 0;
        sb[3] = (dq_ev & dq_en) != 0;
        `CHK(status_byte_o, sb)
        `CHK(per_phase_summary_o, pp)
    endtask

    // edges are judged against the previous levels; inputs settle before reads
    task automatic drive(input logic [31:0] r);
        int n;
        @(posedge clk_i);
        op_done_i <= r[2:0];
        fault_i <= r[7:3];
        phase_fault_i <= r[22:8];
        n = omap(r[2:0]);
        op_ev |= n & ~op_old;
        op_old = n;
        n = fmap(r[7:3]);
        dq_ev |= n & ~dq_old;
        dq_old = n;
        for (int i = 0; i < 3; i++)
        begin
            n = fmap(r[8 + 5 * i +: 5]);
            ph_ev[i] |= (rise[i] & n & ~ph_old[i]) | (fall[i] & ph_old[i] & ~n);
            ph_old[i] = n;
        end
        repeat (6) @(posedge clk_i);
        sums();
    endtask

    initial
    begin
        #100000;
        num_errors++;
        test_done();
    end

    initial
    begin
        clk_i = 1'b0;
        reset_n_i = 1'b0;
        op_done_i = '0;
        fault_i = '0;
        phase_fault_i = '0;
        cmd_valid_i = 1'b0;
        cmd_i = '0;
        {op_ev, dq_ev, op_en, dq_en, op_old, dq_old} = '0;
        for (int i = 0; i < 3; i++)
        begin
            {ph_ev[i], ph_en[i], fall[i], ph_old[i]} = '0;
            rise[i] = 16'h120b;
        end
        v = $urandom(50);
        repeat (10) @(posedge clk_i);
        reset_n_i <= 1'b1;
        rdchk(4'h2, 0);
        rdchk(4'h8, 0);
        rdchk(4'h5, 0);
        rdchk(4'h9, 16'h120b);
        rdchk(4'ha, 0);
        // writes to status-only places and reads of unmapped selectors are refused
        foreach (ro_sel[k])
            cmd(1'b1, ro_sel[k], 16'h1234, 1'b1);
        for (int s = 12; s < 16; s++)
            cmd(1'b0, s[3:0], 16'h0000, 1'b1);
        // limits, one above and exactly at the top; the phase selector only one above
        cmd(1'b1, 4'h2, 16'h7fd8, 1'b1);
        cmd(1'b1, 4'h2, 16'h7fd7, 1'b0);
        op_en = 32727;
        rdchk(4'h2, 32727);
        cmd(1'b1, 4'h8, 16'h8000, 1'b1);
        cmd(1'b1, 4'h8, 16'h7fff, 1'b0);
        ph_en[0] = 32767;
        rdchk(4'h8, 32767);
        cmd(1'b1, 4'hb, 16'h0003, 1'b1);
        rdchk(4'hb, 0);
        repeat (40)
        begin
            p = $urandom_range(0, 2);
            cmd(1'b1, 4'hb, p[15:0], 1'b0);
            v = $urandom_range(0, 32727);
            cmd(1'b1, 4'h2, v[15:0], 1'b0);
            op_en = v;
            v = $urandom;
            cmd(1'b1, 4'h5, v[15:0], 1'b0);
            dq_en = v[15:0];
            v = $urandom_range(0, 32767);
            cmd(1'b1, 4'h8, v[15:0], 1'b0);
            ph_en[p] = v;
            v = $urandom;
            cmd(1'b1, 4'h9, v[15:0], 1'b0);
            rise[p] = v[15:0] & 16'h120b;
            cmd(1'b1, 4'ha, v[31:16], 1'b0);
            fall[p] = v[31:16] & 16'h120b;
            sums();
            drive($urandom);
            rdchk(4'h1, op_old);
            rdchk(4'h4, dq_old);
            rdchk(4'h7, ph_old[p]);
            rdchk(4'h8, ph_en[p]);
            rdchk(4'h5, dq_en);
            rdchk(4'h9, rise[p]);
            rdchk(4'ha, fall[p]);
            rdchk(4'hb, p);
            if ($urandom_range(0, 1) == 1)
            begin
                rdchk(4'h0, op_ev);
                op_ev = 0;
                rdchk(4'h3, dq_ev);
                dq_ev = 0;
                rdchk(4'h6, ph_ev[p]);
                ph_ev[p] = 0;
                rdchk(4'h3, 0);
                rdchk(4'h0, 0);
                sums();
            end
        end
        test_done();
    end
endmodule
